// ### design/audio_serial_fifo_status_irq.sv
`timescale 1ns/1ns
`default_nettype none

module audio_serial_fifo_status_irq (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic tx_pop_i,
    input wire logic tx_shifter_idle_i,
    input wire logic tx_channel_right_i,
    output logic [31:0] tx_data_o,
    input wire logic rx_push_i,
    input wire logic [31:0] rx_data_i,
    output logic tx_dma_req_o,
    output logic rx_dma_req_o,
    output logic irq_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wdat,
                                               input logic [3:0] sel, input logic [31:0] rw);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & rw;
        return (old & ~m) | (wdat & m);
    endfunction

    function automatic logic [31:0] byte_strobe(input logic [31:0] wdat, input logic [3:0] sel);
        return wdat & {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic [31:0] rdata_r, ctrl_r, irq_enable_mask_r, status_rd, w1c;
    logic ack_r, acc, wr_ctrl, wr_ie, wr_status, wr_txport, rd_rxport;

    // Side effects happen on the edge the master samples ack, once per ack; a request
    // still held after ack is acked and acted on again two cycles later.
    assign acc = wb_cyc_i & wb_stb_i & ack_r;
    assign wr_ctrl = acc & wb_we_i & (wb_adr_i == audio_fifo_pkg::CTRL_OFS);
    assign wr_ie = acc & wb_we_i & (wb_adr_i == audio_fifo_pkg::IRQ_ENABLE_MASK_OFS);
    assign wr_status = acc & wb_we_i & (wb_adr_i == audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS);
    assign wr_txport = acc & wb_we_i & (wb_adr_i == audio_fifo_pkg::TRANSMIT_FIFO_PORT_OFS);
    assign rd_rxport = acc & ~wb_we_i & (wb_adr_i == audio_fifo_pkg::RECEIVE_FIFO_PORT_OFS);
    assign w1c = wr_status ? byte_strobe(wb_dat_i, wb_sel_i) : 32'h0000_0000;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    logic tx_flush, rx_flush;
    logic [2:0] tx_threshold_setting, rx_threshold_setting;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r <= audio_fifo_pkg::CTRL_RESET;
            irq_enable_mask_r <= audio_fifo_pkg::IE_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= byte_merge(ctrl_r, wb_dat_i, wb_sel_i, audio_fifo_pkg::CTRL_RW_MASK);
            end
            if (wr_ie) begin
                irq_enable_mask_r <= byte_merge(irq_enable_mask_r, wb_dat_i, wb_sel_i,
                                                audio_fifo_pkg::IE_RW_MASK);
            end
        end
    end

    // Flush bits are not stored, so they read back as zero
    assign tx_flush = wr_ctrl & wb_sel_i[2] & wb_dat_i[audio_fifo_pkg::CTRL_TX_FLUSH_BIT];
    assign rx_flush = wr_ctrl & wb_sel_i[2] & wb_dat_i[audio_fifo_pkg::CTRL_RX_FLUSH_BIT];
    assign tx_threshold_setting = ctrl_r[audio_fifo_pkg::CTRL_TX_LIMIT_LSB +: 3];
    assign rx_threshold_setting = ctrl_r[audio_fifo_pkg::CTRL_RX_LIMIT_LSB +: 3];

    // ----------------------------------------------------------------
    // Transmit buffer
    // ----------------------------------------------------------------
    logic [31:0] tx_mem [audio_fifo_pkg::FIFO_DEPTH];
    logic [2:0] tx_wr_r, tx_rd_r;
    logic [3:0] tx_level_r;
    logic tx_buffer_empty, tx_buffer_full, tx_push, tx_take;

    assign tx_buffer_empty = (tx_level_r == 4'h0);
    assign tx_buffer_full = (tx_level_r == audio_fifo_pkg::FIFO_FULL_LEVEL);
    assign tx_push = wr_txport & ~tx_buffer_full;
    assign tx_take = tx_pop_i & ~tx_buffer_empty;

    always_ff @(posedge ref_clk_i) begin
        if (tx_push) begin
            tx_mem[tx_wr_r] <= wb_dat_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_wr_r <= 3'h0;
            tx_rd_r <= 3'h0;
            tx_level_r <= 4'h0;
            tx_data_o <= 32'h0000_0000;
        end else if (tx_flush) begin
            // Stored words are left in place; only the pointers and the level are cleared
            tx_wr_r <= 3'h0;
            tx_rd_r <= 3'h0;
            tx_level_r <= 4'h0;
        end else begin
            if (tx_push) begin
                tx_wr_r <= tx_wr_r + 3'h1;
            end
            if (tx_take) begin
                tx_rd_r <= tx_rd_r + 3'h1;
                tx_data_o <= tx_mem[tx_rd_r];
            end
            tx_level_r <= tx_level_r + {3'h0, tx_push} - {3'h0, tx_take};
        end
    end

    // ----------------------------------------------------------------
    // Receive buffer
    // ----------------------------------------------------------------
    logic [31:0] rx_mem [audio_fifo_pkg::FIFO_DEPTH];
    logic [2:0] rx_wr_r, rx_rd_r;
    logic [3:0] rx_level_r;
    logic rx_buffer_empty, rx_buffer_full, rx_pop, rx_overrun;

    assign rx_buffer_empty = (rx_level_r == 4'h0);
    assign rx_buffer_full = (rx_level_r == audio_fifo_pkg::FIFO_FULL_LEVEL);
    assign rx_pop = rd_rxport & ~rx_buffer_empty;
    assign rx_overrun = rx_push_i & rx_buffer_full & ~rx_pop;

    always_ff @(posedge ref_clk_i) begin
        if (rx_push_i) begin
            rx_mem[rx_wr_r] <= rx_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_wr_r <= 3'h0;
            rx_rd_r <= 3'h0;
            rx_level_r <= 4'h0;
        end else if (rx_flush) begin
            rx_wr_r <= 3'h0;
            rx_rd_r <= 3'h0;
            rx_level_r <= 4'h0;
        end else begin
            if (rx_push_i) begin
                rx_wr_r <= rx_wr_r + 3'h1;
            end
            // On overrun the write lands on the oldest entry, which is dropped
            if (rx_pop || rx_overrun) begin
                rx_rd_r <= rx_rd_r + 3'h1;
            end
            if (!rx_overrun) begin
                rx_level_r <= rx_level_r + {3'h0, rx_push_i} - {3'h0, rx_pop};
            end
        end
    end

    // ----------------------------------------------------------------
    // Event flags (a set in the clearing cycle wins)
    // ----------------------------------------------------------------
    logic tx_overflow_flag, tx_underflow_flag, rx_overflow_flag, rx_underflow_flag;
    logic left_zero_cross_flag, right_zero_cross_flag, zc_hit;
    logic [1:0] last_sign_r;

    assign zc_hit = (tx_mem[tx_rd_r][audio_fifo_pkg::SAMPLE_SIGN_BIT] != last_sign_r[tx_channel_right_i])
                    | (tx_mem[tx_rd_r] == 32'h0000_0000);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_overflow_flag <= 1'b0;
            tx_underflow_flag <= 1'b0;
            rx_overflow_flag <= 1'b0;
            rx_underflow_flag <= 1'b0;
        end else begin
            tx_overflow_flag <= (wr_txport & tx_buffer_full)
                                | (tx_overflow_flag & ~w1c[audio_fifo_pkg::ST_TX_OVER_BIT]);
            tx_underflow_flag <= (tx_pop_i & tx_buffer_empty)
                                 | (tx_underflow_flag & ~w1c[audio_fifo_pkg::ST_TX_UNDER_BIT]);
            rx_overflow_flag <= rx_overrun
                                | (rx_overflow_flag & ~w1c[audio_fifo_pkg::ST_RX_OVER_BIT]);
            rx_underflow_flag <= (rd_rxport & rx_buffer_empty)
                                 | (rx_underflow_flag & ~w1c[audio_fifo_pkg::ST_RX_UNDER_BIT]);
        end
    end

    // Sign history per channel is kept only for words actually sent
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            last_sign_r <= 2'b00;
            left_zero_cross_flag <= 1'b0;
            right_zero_cross_flag <= 1'b0;
        end else begin
            if (tx_take) begin
                last_sign_r[tx_channel_right_i] <= tx_mem[tx_rd_r][audio_fifo_pkg::SAMPLE_SIGN_BIT];
            end
            left_zero_cross_flag <= (tx_take & ~tx_channel_right_i & zc_hit
                                     & ctrl_r[audio_fifo_pkg::CTRL_LZC_EN_BIT])
                                    | (left_zero_cross_flag & ~w1c[audio_fifo_pkg::ST_LEFT_ZC_BIT]);
            right_zero_cross_flag <= (tx_take & tx_channel_right_i & zc_hit
                                      & ctrl_r[audio_fifo_pkg::CTRL_RZC_EN_BIT])
                                     | (right_zero_cross_flag & ~w1c[audio_fifo_pkg::ST_RIGHT_ZC_BIT]);
        end
    end

    // ----------------------------------------------------------------
    // Busy, thresholds and interrupt status
    // ----------------------------------------------------------------
    logic tx_shifter_active, tx_threshold_flag, rx_threshold_flag;
    logic transmit_irq_status, receive_irq_status, combined_irq_status;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_shifter_active <= 1'b0;
        end else if (tx_take) begin
            tx_shifter_active <= 1'b1;
        end else if (tx_buffer_empty && tx_shifter_idle_i) begin
            tx_shifter_active <= 1'b0;
        end
    end

    assign tx_threshold_flag = (tx_level_r <= {1'b0, tx_threshold_setting});
    assign rx_threshold_flag = (rx_level_r >= ({1'b0, rx_threshold_setting} + 4'h1));

    assign transmit_irq_status =
        (tx_threshold_flag & irq_enable_mask_r[audio_fifo_pkg::IE_TX_LIMIT_BIT])
        | (tx_overflow_flag & irq_enable_mask_r[audio_fifo_pkg::IE_TX_OVER_BIT])
        | (tx_underflow_flag & irq_enable_mask_r[audio_fifo_pkg::IE_TX_UNDER_BIT])
        | (left_zero_cross_flag & irq_enable_mask_r[audio_fifo_pkg::IE_LZC_BIT])
        | (right_zero_cross_flag & irq_enable_mask_r[audio_fifo_pkg::IE_RZC_BIT]);
    assign receive_irq_status =
        (rx_threshold_flag & irq_enable_mask_r[audio_fifo_pkg::IE_RX_LIMIT_BIT])
        | (rx_overflow_flag & irq_enable_mask_r[audio_fifo_pkg::IE_RX_OVER_BIT])
        | (rx_underflow_flag & irq_enable_mask_r[audio_fifo_pkg::IE_RX_UNDER_BIT]);
    assign combined_irq_status = transmit_irq_status | receive_irq_status;
    assign irq_o = combined_irq_status;

    assign tx_dma_req_o = ctrl_r[audio_fifo_pkg::CTRL_TX_DMA_BIT] & ~tx_buffer_full;
    assign rx_dma_req_o = ctrl_r[audio_fifo_pkg::CTRL_RX_DMA_BIT] & ~rx_buffer_empty;

    always_comb begin
        status_rd = 32'h0000_0000;
        status_rd[audio_fifo_pkg::ST_TXLVL_LSB +: 4] = tx_level_r;
        status_rd[audio_fifo_pkg::ST_RXLVL_LSB +: 4] = rx_level_r;
        status_rd[audio_fifo_pkg::ST_LEFT_ZC_BIT] = left_zero_cross_flag;
        status_rd[audio_fifo_pkg::ST_RIGHT_ZC_BIT] = right_zero_cross_flag;
        status_rd[audio_fifo_pkg::ST_TX_ACTIVE_BIT] = tx_shifter_active;
        status_rd[audio_fifo_pkg::ST_TX_EMPTY_BIT] = tx_buffer_empty;
        status_rd[audio_fifo_pkg::ST_TX_FULL_BIT] = tx_buffer_full;
        status_rd[audio_fifo_pkg::ST_TX_LIMIT_BIT] = tx_threshold_flag;
        status_rd[audio_fifo_pkg::ST_TX_OVER_BIT] = tx_overflow_flag;
        status_rd[audio_fifo_pkg::ST_TX_UNDER_BIT] = tx_underflow_flag;
        status_rd[audio_fifo_pkg::ST_RX_EMPTY_BIT] = rx_buffer_empty;
        status_rd[audio_fifo_pkg::ST_RX_FULL_BIT] = rx_buffer_full;
        status_rd[audio_fifo_pkg::ST_RX_LIMIT_BIT] = rx_threshold_flag;
        status_rd[audio_fifo_pkg::ST_RX_OVER_BIT] = rx_overflow_flag;
        status_rd[audio_fifo_pkg::ST_RX_UNDER_BIT] = rx_underflow_flag;
        status_rd[audio_fifo_pkg::ST_RIGHT_BIT] = tx_channel_right_i;
        status_rd[audio_fifo_pkg::ST_TXINT_BIT] = transmit_irq_status;
        status_rd[audio_fifo_pkg::ST_RXINT_BIT] = receive_irq_status;
        status_rd[audio_fifo_pkg::ST_INT_BIT] = combined_irq_status;
    end

    // Read data is captured with ack; the transmit port reads as zero
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
            unique case (wb_adr_i)
                audio_fifo_pkg::CTRL_OFS: rdata_r <= ctrl_r;
                audio_fifo_pkg::IRQ_ENABLE_MASK_OFS: rdata_r <= irq_enable_mask_r;
                audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS: rdata_r <= status_rd;
                audio_fifo_pkg::RECEIVE_FIFO_PORT_OFS: rdata_r <= rx_mem[rx_rd_r];
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_tx_overflow_set: assert property (wr_txport && tx_buffer_full |=> tx_overflow_flag)
        else $error("tx overflow flag not set");
    a_tx_underflow_set: assert property (tx_pop_i && tx_buffer_empty |=> tx_underflow_flag)
        else $error("tx underflow flag not set");
    a_rx_underflow_set: assert property (rd_rxport && rx_buffer_empty |=> rx_underflow_flag)
        else $error("rx underflow flag not set");
    a_rx_overrun_keeps: assert property (rx_overrun && !rx_flush |=> rx_overflow_flag && rx_buffer_full)
        else $error("rx overrun handling wrong");
    a_flush_empties_tx: assert property (tx_flush |=> tx_buffer_empty && tx_threshold_flag)
        else $error("tx flush did not empty");
    a_tx_push_level: assert property (tx_push && !tx_take && !tx_flush
                                      |=> tx_level_r == $past(tx_level_r) + 4'h1)
        else $error("tx level did not grow");
    a_rx_pop_level: assert property (rx_pop && !rx_push_i && !rx_flush
                                     |=> rx_level_r == $past(rx_level_r) - 4'h1)
        else $error("rx level did not drop");
    a_left_zc_irq: assert property (left_zero_cross_flag && irq_enable_mask_r[audio_fifo_pkg::IE_LZC_BIT]
                                    |-> irq_o && status_rd[audio_fifo_pkg::ST_TXINT_BIT])
        else $error("left zero cross irq missing");
    a_level_bounded: assert property (tx_level_r <= 4'h8 && rx_level_r <= 4'h8)
        else $error("level out of range");
    a_busy_holds: assert property (tx_shifter_active && !(tx_buffer_empty && tx_shifter_idle_i)
                                   |=> tx_shifter_active)
        else $error("busy dropped early");
    a_bus_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    c_tx_fill: cover property (tx_buffer_full ##1 tx_take);
    c_rx_overrun: cover property (rx_overrun);
    c_irq_raise: cover property (!irq_o ##1 irq_o);
    c_zc_clear: cover property (left_zero_cross_flag ##1 !left_zero_cross_flag);

endmodule

`default_nettype wire

// ### pkg/audio_fifo_pkg.sv
package audio_fifo_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_MASK_OFS = 8'h08;
    localparam logic [7:0] FIFO_AND_IRQ_STATUS_OFS = 8'h0c;
    localparam logic [7:0] TRANSMIT_FIFO_PORT_OFS = 8'h10;
    localparam logic [7:0] RECEIVE_FIFO_PORT_OFS = 8'h14;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int CTRL_RX_DMA_BIT = 21;
    localparam int CTRL_TX_DMA_BIT = 20;
    localparam int CTRL_RX_FLUSH_BIT = 19;
    localparam int CTRL_TX_FLUSH_BIT = 18;
    localparam int CTRL_LZC_EN_BIT = 17;
    localparam int CTRL_RZC_EN_BIT = 16;
    localparam int CTRL_RX_LIMIT_LSB = 12;
    localparam int CTRL_TX_LIMIT_LSB = 9;
    localparam logic [31:0] CTRL_RW_MASK = 32'h0033_7e00;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Interrupt enable fields
    // ----------------------------------------------------------------
    localparam int IE_LZC_BIT = 12;
    localparam int IE_RZC_BIT = 11;
    localparam int IE_TX_LIMIT_BIT = 10;
    localparam int IE_TX_OVER_BIT = 9;
    localparam int IE_TX_UNDER_BIT = 8;
    localparam int IE_RX_LIMIT_BIT = 2;
    localparam int IE_RX_OVER_BIT = 1;
    localparam int IE_RX_UNDER_BIT = 0;
    localparam logic [31:0] IE_RW_MASK = 32'h0000_1f07;
    localparam logic [31:0] IE_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Status fields
    // ----------------------------------------------------------------
    localparam int ST_TXLVL_LSB = 28;
    localparam int ST_RXLVL_LSB = 24;
    localparam int ST_LEFT_ZC_BIT = 23;
    localparam int ST_RIGHT_ZC_BIT = 22;
    localparam int ST_TX_ACTIVE_BIT = 21;
    localparam int ST_TX_EMPTY_BIT = 20;
    localparam int ST_TX_FULL_BIT = 19;
    localparam int ST_TX_LIMIT_BIT = 18;
    localparam int ST_TX_OVER_BIT = 17;
    localparam int ST_TX_UNDER_BIT = 16;
    localparam int ST_RX_EMPTY_BIT = 12;
    localparam int ST_RX_FULL_BIT = 11;
    localparam int ST_RX_LIMIT_BIT = 10;
    localparam int ST_RX_OVER_BIT = 9;
    localparam int ST_RX_UNDER_BIT = 8;
    localparam int ST_RIGHT_BIT = 3;
    localparam int ST_TXINT_BIT = 2;
    localparam int ST_RXINT_BIT = 1;
    localparam int ST_INT_BIT = 0;
    localparam logic [31:0] STATUS_RESET = 32'h0014_1000;

    // ----------------------------------------------------------------
    // FIFO geometry
    // ----------------------------------------------------------------
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] FIFO_FULL_LEVEL = 4'h8;
    localparam int SAMPLE_SIGN_BIT = 31;

endpackage

// ### sim/shift_partner.sv
`timescale 1ns/1ns
`default_nettype none
module shift_partner (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic beat_o,
    output logic tx_idle_o,
    output logic chan_right_o,
    output logic [31:0] rx_data_o,
    output logic [7:0] cnt_o
);
    // ------------------------------------------------------------
    // Link clock, halted between frames
    // ------------------------------------------------------------
    logic lclk = 1'b0;
    logic lclk_q;
    always #80 if (run_i) lclk = ~lclk;
    assign tx_idle_o = ~run_i;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lclk_q <= 1'b0;
            beat_o <= 1'b0;
            chan_right_o <= 1'b0;
            rx_data_o <= 32'h0;
            cnt_o <= 8'h00;
        end else begin
            lclk_q <= lclk;
            beat_o <= lclk & ~lclk_q;
            // Idle data flips so a stale word is never mistaken for a fresh one
            rx_data_o <= (lclk & ~lclk_q) ? {24'h000001, cnt_o} : ~rx_data_o;
            if (beat_o) begin
                cnt_o <= cnt_o + 8'h01;
                chan_right_o <= ~chan_right_o;
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, run = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat = 32'h0, q;
    wire logic ack, beat, idle, rgt, txrq, rxrq, irq;
    wire logic [31:0] rdat, txd, rxd;
    wire logic [7:0] cnt;
    int mismatches = 0, compares = 0, cyc_n = 0;
    initial forever #5 clk = ~clk;
    audio_serial_fifo_status_irq dut_u (.ref_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tx_pop_i(beat), .tx_shifter_idle_i(idle), .tx_channel_right_i(rgt), .tx_data_o(txd),
        .rx_push_i(beat), .rx_data_i(rxd), .tx_dma_req_o(txrq), .rx_dma_req_o(rxrq), .irq_o(irq));
    shift_partner sp_u (.ref_clk_i(clk), .rst_i(rst), .run_i(run), .beat_o(beat), .tx_idle_o(idle),
        .chan_right_o(rgt), .rx_data_o(rxd), .cnt_o(cnt));
    task automatic give_verdict();
        if (mismatches == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic single cycle; the answer is awaited, the timeout bounds it
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_reset();
        bus(0, audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS, 0); chk(q, audio_fifo_pkg::STATUS_RESET);
        bus(0, audio_fifo_pkg::IRQ_ENABLE_MASK_OFS, 0); chk(q, audio_fifo_pkg::IE_RESET);
        bus(0, 8'h1c, 0); chk(q, 32'h0);
        bus(1, audio_fifo_pkg::CTRL_OFS, 32'h0030_0000);
        chk({txrq, rxrq}, 2'b10);
    endtask
    task automatic t_txfill();
        for (int i = 0; i < 9; i++) bus(1, audio_fifo_pkg::TRANSMIT_FIFO_PORT_OFS, 32'ha0 + i);
        bus(0, audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS, 0); chk(q, 32'h800a_1000);
        chk({txrq, irq}, 2'b00);
        bus(1, audio_fifo_pkg::IRQ_ENABLE_MASK_OFS, 32'h200);
        bus(0, audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS, 0); chk(q, 32'h800a_1005);
        chk(irq, 1'b1);
        bus(1, audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS, 32'h0002_0000);
        bus(0, audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS, 0); chk(q, 32'h8008_1000);
        bus(1, audio_fifo_pkg::IRQ_ENABLE_MASK_OFS, 32'h0);
    endtask
    task automatic t_stream();
        run <= 1'b1;
        while (cnt !== 8'd12) @(posedge clk);
        run <= 1'b0;
        repeat (3) @(posedge clk);
        chk(txd, 32'ha7);
        chk({txrq, rxrq}, 2'b11);
        bus(0, audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS, 0); chk(q, 32'h0815_0e00);
        bus(1, audio_fifo_pkg::IRQ_ENABLE_MASK_OFS, 32'h100);
        bus(0, audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS, 0); chk(q, 32'h0815_0e05);
        bus(1, audio_fifo_pkg::IRQ_ENABLE_MASK_OFS, 32'h2);
        bus(0, audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS, 0); chk(q, 32'h0815_0e03);
    endtask
    task automatic t_rxread();
        for (int i = 0; i < 8; i++) begin
            bus(0, audio_fifo_pkg::RECEIVE_FIFO_PORT_OFS, 0); chk(q, 32'h104 + i);
        end
        bus(0, audio_fifo_pkg::RECEIVE_FIFO_PORT_OFS, 0);
        bus(0, audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS, 0); chk(q, 32'h0015_1303);
        chk(irq, 1'b1);
    endtask
    // Link runs until the beat counter reaches n, then the shifter idles
    task automatic beats(input logic [7:0] n);
        run <= 1'b1;
        while (cnt !== n) @(posedge clk);
        run <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic t_zc_flush();
        bus(1, audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS, 32'h0001_0300);
        bus(1, audio_fifo_pkg::IRQ_ENABLE_MASK_OFS, 32'h1c04);
        bus(1, audio_fifo_pkg::CTRL_OFS, 32'h0003_2600);
        bus(1, audio_fifo_pkg::TRANSMIT_FIFO_PORT_OFS, 32'h8000_0001);
        bus(1, audio_fifo_pkg::TRANSMIT_FIFO_PORT_OFS, 32'h0000_0005);
        bus(1, audio_fifo_pkg::TRANSMIT_FIFO_PORT_OFS, 32'h8000_0002);
        bus(1, audio_fifo_pkg::TRANSMIT_FIFO_PORT_OFS, 32'h0000_0000);
        bus(0, audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS, 0); chk(q, 32'h4000_1000);
        chk(irq, 1'b0);
        beats(8'd14);
        chk(txd, 32'h0000_0005);
        bus(0, audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS, 0); chk(q, 32'h22a4_0005);
        chk(irq, 1'b1);
        bus(1, audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS, 32'h0080_0000);
        beats(8'd16);
        bus(0, audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS, 0); chk(q, 32'h0454_0407);
        bus(1, audio_fifo_pkg::CTRL_OFS, 32'h000f_2600);
        bus(0, audio_fifo_pkg::FIFO_AND_IRQ_STATUS_OFS, 0); chk(q, 32'h0054_1005);
        bus(0, audio_fifo_pkg::CTRL_OFS, 0); chk(q, 32'h0003_2600);
    endtask
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_txfill();
        t_stream();
        t_rxread();
        t_zc_flush();
        give_verdict();
    end
endmodule
`default_nettype wire
